// ==== hw/ppt_defines.svh ====
// register offsets, reset values and field positions of the parallel port
`ifndef PPT_DEFINES_SVH
`define PPT_DEFINES_SVH
`define PPT_OFF_FUNC_SEL   12'h004
`define PPT_OFF_DIR        12'h244
`define PPT_OFF_VALUE      12'h248
`define PPT_RST_DIR        16'h0000
`define PPT_RST_VALUE      16'h0000
`define PPT_FUNC_ALL_PORT  16'h0000
`define PPT_FUNC_ALL_ALT   16'hFFFF
`define PPT_BIT_XFER_ACT   7
`define PPT_BIT_DREQ0      6
`define PPT_BIT_DREQ1      5
`define PPT_BIT_TM_HI      4
`define PPT_BIT_TM_LO      2
`define PPT_BIT_TT_HI      1
`define PPT_BIT_TT_LO      0
`define PPT_BIT_ADDR_LO    8
`endif

// ==== hw/ppt_pkg.sv ====
// types shared by the parallel port design
package ppt_pkg;
   typedef enum logic [1:0] {PPT_SEL_NONE, PPT_SEL_FUNC, PPT_SEL_DIR, PPT_SEL_VALUE} ppt_sel_type;
   typedef enum {PPT_RESET, PPT_RUN} ppt_state_type;
endpackage

// ==== hw/ppt_port.sv ====
// sixteen pin parallel port with per-pin function select, direction and value registers
// Behaviour
// - each function-select bit: 0 port pin, 1 alternate bus function, independently
// - select bits 15..8 hand pins 15..8 to address bits 31..24
// - select bit 7 hands pin 7 to the transfer-active output, low active
// - select bits 6,5 hand pins to dma request inputs 0 and 1
// - select bits 4..2 hand pins to the three transfer-modifier outputs
// - select bits 1,0 hand pins to the two transfer-kind outputs
// - select register resets from config pin at reset release: low ports, high alternates
// - upper pins may be ports while low address bits stay in use
// - direction bit 0 input, 1 output; resets to zero
// - reading value returns pin level for input port pins
// - writing value of an input pin stores but does not drive
// - reading value of output pin returns stored bit; pin driven with it
// - writing value of output pin changes the pin one cycle after the register
// - value register never drives pins given to alternate functions
// - value register writable anytime except the strap cycle after reset release; resets to zero
// - registers reachable by internal processor and external bus master alike
`timescale 1ns/100ps
`include "ppt_defines.svh"
module ppt_port
   import ppt_pkg::*;
(
   input  wire logic        I_CLK_SYS,            // system bus clock
   input  wire logic        I_RST,                // synchronous reset, active high
   input  wire logic        I_ADDR_CONFIG,        // configuration data pin sampled at reset release
   input  wire logic [11:0] I_REG_ADDR,           // offset from module base address
   input  wire logic        I_REG_SEL,            // register access strobe, processor or external master
   input  wire logic        I_REG_WR,             // 1 write, 0 read
   input  wire logic [15:0] I_REG_WDATA,          // write data
   output logic      [15:0] O_REG_RDATA,          // read data, registered
   output logic             O_REG_ACK,            // access done pulse
   input  wire logic [15:0] I_PORT_PIN,           // pin levels
   output logic      [15:0] O_PORT_PIN,           // pin drive value
   output logic      [15:0] O_PORT_PIN_OE,        // pin drive enable
   output logic      [15:0] O_PIN_FUNC_SEL,       // current function select to alternate bus logic
   input  wire logic [7:0]  I_ADDR_HI,            // address bits 31..24 from bus logic
   input  wire logic        I_BUS_TRANSFER_ACTIVE_N, // transfer-active from bus logic
   input  wire logic [2:0]  I_TRANSFER_MODIFIER,  // modifier from bus logic
   input  wire logic [1:0]  I_TRANSFER_KIND,      // transfer kind from bus logic
   input  wire logic        I_BUS_MASTER,         // device owns the bus
   output logic      [1:0]  O_DMA_REQUEST_IN      // dma requests 1..0 to dma logic
);

   ppt_state_type state_q, state_d;
   logic [15:0] func_q, func_d;
   logic [15:0] dir_q, dir_d;
   logic [15:0] val_q, val_d;
   logic [15:0] rdata_q, rdata_d;
   logic        ack_q, ack_d;
   logic [15:0] pin_q, pin_d;
   logic [15:0] oe_q, oe_d;
   logic [1:0]  dma_request_in_q, dma_request_in_d;
   ppt_sel_type sel;

   // shared offset decode
   function automatic ppt_sel_type decode(input logic [11:0] a);
      if (a == `PPT_OFF_FUNC_SEL)   return PPT_SEL_FUNC;
      else if (a == `PPT_OFF_DIR)   return PPT_SEL_DIR;
      else if (a == `PPT_OFF_VALUE) return PPT_SEL_VALUE;
      else                          return PPT_SEL_NONE;
   endfunction

   assign sel = decode(I_REG_ADDR);

   // register file next state; one slave port serves every bus master
   always_comb begin
      state_d = state_q;
      func_d  = func_q;
      dir_d   = dir_q;
      val_d   = val_q;
      rdata_d = 16'h0000;
      ack_d   = I_REG_SEL;
      unique case (state_q)
         PPT_RESET: begin
            func_d  = I_ADDR_CONFIG ? `PPT_FUNC_ALL_ALT : `PPT_FUNC_ALL_PORT;
            state_d = PPT_RUN;
            ack_d   = 1'b0;
         end
         PPT_RUN: begin
            if (I_REG_SEL && I_REG_WR) begin
               if (sel == PPT_SEL_FUNC) func_d = I_REG_WDATA;
               if (sel == PPT_SEL_DIR) dir_d = I_REG_WDATA;
               if (sel == PPT_SEL_VALUE) val_d = I_REG_WDATA;
            end
            if (I_REG_SEL && !I_REG_WR) begin
               unique case (sel)
                  PPT_SEL_FUNC:  rdata_d = func_q;
                  PPT_SEL_DIR:   rdata_d = dir_q;
                  // input pins read pin, outputs read store
                  PPT_SEL_VALUE: rdata_d = (dir_q & val_q) | (~dir_q & I_PORT_PIN);
                  PPT_SEL_NONE:  rdata_d = 16'h0000;
               endcase
            end
         end
      endcase
   end

   // register file flops; a request in the strap cycle after release is dropped, not delayed
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         state_q <= PPT_RESET;
         func_q  <= `PPT_FUNC_ALL_PORT;
         dir_q   <= `PPT_RST_DIR;
         val_q   <= `PPT_RST_VALUE;
         rdata_q <= 16'h0000;
         ack_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         func_q  <= func_d;
         dir_q   <= dir_d;
         val_q   <= val_d;
         rdata_q <= rdata_d;
         ack_q   <= ack_d;
      end
   end

   // pin mux next values
   always_comb begin
      // port outputs carry the stored bit, alternates ignore it
      pin_d = val_q;
      oe_d  = dir_q & ~func_q;
      // address bits per pin, independent of lower pins
      for (int i = `PPT_BIT_ADDR_LO; i < 16; i++) begin
         if (func_q[i]) begin
            pin_d[i] = I_ADDR_HI[i - `PPT_BIT_ADDR_LO];
            oe_d[i]  = I_BUS_MASTER;
         end
      end
      if (func_q[`PPT_BIT_XFER_ACT]) begin
         pin_d[`PPT_BIT_XFER_ACT] = I_BUS_TRANSFER_ACTIVE_N;
         oe_d[`PPT_BIT_XFER_ACT]  = I_BUS_MASTER;
      end
      // dma requests are inputs, driver stays off
      if (func_q[`PPT_BIT_DREQ0]) oe_d[`PPT_BIT_DREQ0] = 1'b0;
      if (func_q[`PPT_BIT_DREQ1]) oe_d[`PPT_BIT_DREQ1] = 1'b0;
      for (int i = `PPT_BIT_TM_LO; i <= `PPT_BIT_TM_HI; i++) begin
         if (func_q[i]) begin
            pin_d[i] = I_TRANSFER_MODIFIER[i - `PPT_BIT_TM_LO];
            oe_d[i]  = I_BUS_MASTER;
         end
      end
      // transfer kind driven only as bus master
      for (int i = `PPT_BIT_TT_LO; i <= `PPT_BIT_TT_HI; i++) begin
         if (func_q[i]) begin
            pin_d[i] = I_TRANSFER_KIND[i - `PPT_BIT_TT_LO];
            oe_d[i]  = I_BUS_MASTER;
         end
      end
      // requests read zero while pins are ports
      dma_request_in_d[0] = func_q[`PPT_BIT_DREQ0] & I_PORT_PIN[`PPT_BIT_DREQ0];
      dma_request_in_d[1] = func_q[`PPT_BIT_DREQ1] & I_PORT_PIN[`PPT_BIT_DREQ1];
   end

   // pin flops; one cycle of latency is the price of registered outputs
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         pin_q  <= 16'h0000;
         oe_q   <= 16'h0000;
         dma_request_in_q <= 2'b00;
      end else begin
         pin_q  <= pin_d;
         oe_q   <= oe_d;
         dma_request_in_q <= dma_request_in_d;
      end
   end

   assign O_REG_RDATA      = rdata_q;
   assign O_REG_ACK        = ack_q;
   assign O_PORT_PIN       = pin_q;
   assign O_PORT_PIN_OE    = oe_q;
   assign O_PIN_FUNC_SEL   = func_q;
   assign O_DMA_REQUEST_IN = dma_request_in_q;

endmodule // ppt_port

// ==== tb/ppt_port_sva.sv ====
// concurrent checks on the parallel port ports
`timescale 1ns/100ps
module ppt_port_sva (
   input wire logic        I_CLK_SYS, I_RST, I_ADDR_CONFIG, I_REG_SEL, I_REG_WR, I_BUS_MASTER,
   input wire logic        I_BUS_TRANSFER_ACTIVE_N, O_REG_ACK,
   input wire logic [11:0] I_REG_ADDR,
   input wire logic [15:0] I_REG_WDATA, O_REG_RDATA, I_PORT_PIN, O_PORT_PIN, O_PORT_PIN_OE, O_PIN_FUNC_SEL,
   input wire logic [7:0]  I_ADDR_HI,
   input wire logic [2:0]  I_TRANSFER_MODIFIER,
   input wire logic [1:0]  I_TRANSFER_KIND, O_DMA_REQUEST_IN
);
   logic run_q; // low in the strap cycle, where requests are ignored
   wire  fwr = I_REG_SEL & I_REG_WR & run_q & (I_REG_ADDR == 12'h004);
   wire  frd = I_REG_SEL & ~I_REG_WR & run_q & (I_REG_ADDR == 12'h004);
   // remember whether the previous edge was out of reset
   always_ff @(posedge I_CLK_SYS) begin
      run_q <= !I_RST;
   end
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);
   a_ack_taken: assert property (I_REG_SEL && run_q |=> O_REG_ACK)
      else $error("access not acknowledged");
   a_strap_load: assert property (!run_q |=> O_PIN_FUNC_SEL == {16{$past(I_ADDR_CONFIG)}})
      else $error("select not loaded from strap");
   a_func_write: assert property (fwr |=> O_PIN_FUNC_SEL == $past(I_REG_WDATA))
      else $error("select write lost");
   a_func_read: assert property (frd |=> O_REG_RDATA == $past(O_PIN_FUNC_SEL))
      else $error("select read wrong");
   a_func_hold: assert property (run_q && !fwr |=> $stable(O_PIN_FUNC_SEL))
      else $error("select changed without write");
   a_alt_enable: assert property ((O_PORT_PIN_OE & $past(O_PIN_FUNC_SEL)) ==
      ($past(O_PIN_FUNC_SEL) & 16'hFF9F & {16{$past(I_BUS_MASTER)}}))
      else $error("alternate pin enable wrong");
   a_alt_value: assert property ($past(I_BUS_MASTER) |-> ((O_PORT_PIN ^ $past({I_ADDR_HI,
      I_BUS_TRANSFER_ACTIVE_N, 2'b00, I_TRANSFER_MODIFIER, I_TRANSFER_KIND})) & $past(O_PIN_FUNC_SEL)
      & 16'hFF9F) == 16'h0000)
      else $error("alternate pin value wrong");
   a_dma_route: assert property (O_DMA_REQUEST_IN == $past({I_PORT_PIN[5] & O_PIN_FUNC_SEL[5],
      I_PORT_PIN[6] & O_PIN_FUNC_SEL[6]}))
      else $error("dma request routing wrong");
endmodule // ppt_port_sva
bind ppt_port ppt_port_sva u_sva (.*);

// ==== tb/ppt_pins.sv ====
// external circuitry on the sixteen pins
`timescale 1ns/100ps
module ppt_pins (
   input  wire logic [15:0] i_oe,     // device drive enable
   input  wire logic [15:0] i_drv,    // device drive value
   input  wire logic [15:0] i_ext,    // far side levels, dma requests among them
   output logic      [15:0] o_level   // resolved pin level
);
   // peripheral drives requests; released device pins show the far side's level
   assign o_level = (i_oe & i_drv) | (~i_oe & i_ext);
endmodule // ppt_pins

// ==== tb/ppt_port_tb.sv ====
// self-checking testbench for the parallel port
`timescale 1ns/100ps
module ppt_port_tb;
   logic        clk = 1'b0, rst = 1'b1, cfg = 1'b0, sel = 1'b0, wr = 1'b0, bm = 1'b1, tan = 1'b0, ack;
   logic [11:0] addr = 12'h000;
   logic [15:0] wdata = 16'h0000, rdata, pin, drv, oe, func, rd, ext = 16'hA5C3;
   logic [7:0]  ahi = 8'h5A;
   logic [2:0]  tm = 3'h5;
   logic [1:0]  tk = 2'h2, dma;
   int          errors = 0, checked = 0;
   ppt_port uut (.I_CLK_SYS(clk), .I_RST(rst), .I_ADDR_CONFIG(cfg), .I_REG_ADDR(addr), .I_REG_SEL(sel),
      .I_REG_WR(wr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_ACK(ack), .I_PORT_PIN(pin),
      .O_PORT_PIN(drv), .O_PORT_PIN_OE(oe), .O_PIN_FUNC_SEL(func), .I_ADDR_HI(ahi),
      .I_BUS_TRANSFER_ACTIVE_N(tan), .I_TRANSFER_MODIFIER(tm), .I_TRANSFER_KIND(tk),
      .I_BUS_MASTER(bm), .O_DMA_REQUEST_IN(dma));
   ppt_pins far (.i_oe(oe), .i_drv(drv), .i_ext(ext), .o_level(pin));
   initial begin
      forever #50 clk = ~clk;
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one register access, driven at the falling edge, answer taken one cycle later
   task acc(input logic w, input logic [11:0] a, input logic [15:0] d);
      @(negedge clk);
      {sel, wr, addr, wdata} = {1'b1, w, a, d};
      @(negedge clk);
      sel = 1'b0;
      rd = rdata;
      chk({15'h0000, ack}, 16'h0001);
   endtask
   task do_reset(input logic c);
      @(negedge clk);
      {rst, cfg} = {1'b1, c};
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task t_reset;
      do_reset(1'b0);
      acc(1'b0, 12'h004, 16'h0000);
      chk(rd, 16'h0000);
      acc(1'b0, 12'h244, 16'h0000);
      chk(rd, 16'h0000);
      acc(1'b0, 12'h248, 16'h0000);
      chk(rd, ext);
      chk(oe, 16'h0000);
      $display("test reset done");
   endtask
   task t_port;
      acc(1'b1, 12'h244, 16'h00F0);
      acc(1'b1, 12'h248, 16'h00A0);
      @(negedge clk);
      chk(oe, 16'h00F0);
      chk(drv & 16'h00F0, 16'h00A0);
      acc(1'b0, 12'h248, 16'h0000);
      chk(rd, (ext & 16'hFF0F) | 16'h00A0);
      acc(1'b1, 12'h248, 16'h1234);
      @(negedge clk);
      chk(oe, 16'h00F0);
      acc(1'b0, 12'h248, 16'h0000);
      chk(rd, (ext & 16'hFF0F) | 16'h0030);
      acc(1'b1, 12'h100, 16'hFFFF);
      acc(1'b0, 12'h100, 16'h0000);
      chk(rd, 16'h0000);
      $display("test port done");
   endtask
   task t_alt;
      logic [15:0] f;
      acc(1'b1, 12'h244, 16'h0000);
      for (int i = 0; i < 2; i++) begin
         f = (i == 0) ? 16'hFFFF : 16'hFC00;
         acc(1'b1, 12'h004, f);
         acc(1'b0, 12'h004, 16'h0000);
         chk(rd, f);
         @(negedge clk);
         chk(func, f);
         chk(oe, f & 16'hFF9F);
         chk(drv & f & 16'hFF9F, {ahi, tan, 2'b00, tm, tk} & f & 16'hFF9F);
         chk({14'h0000, dma}, {14'h0000, ext[5] & f[5], ext[6] & f[6]});
      end
      bm = 1'b0;
      repeat (2) @(negedge clk);
      chk(oe, 16'h0000);
      bm = 1'b1;
      do_reset(1'b1);
      acc(1'b0, 12'h004, 16'h0000);
      chk(rd, 16'hFFFF);
      $display("test alternate done");
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      t_reset;
      t_port;
      t_alt;
      final_report;
   end
   // about fifty cycles are needed, so this limit only trips on a hang
   initial begin
      #100_000;
      errors++;
      final_report;
   end
endmodule // ppt_port_tb
